// ===== verilog/crs_regs.svh
// timing counts for the card slot reset, wake and presence logic
// assumes a 25 MHz system clock; every count derives from the period below
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

`define CRS_CLK_NS         40
// reset low time, least
`define CRS_RSTLOW_MIN_US  100
`define CRS_RSTLOW_MIN_CYC ((`CRS_RSTLOW_MIN_US * 1000 + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// reference clock stable before release, least
`define CRS_REFERENCE_CLOCK_IN_MIN_US  100
`define CRS_REFERENCE_CLOCK_IN_MIN_CYC ((`CRS_REFERENCE_CLOCK_IN_MIN_US * 1000 + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// rails stable before release, least
`define CRS_PWR_MIN_MS     100
`define CRS_PWR_MIN_CYC    ((`CRS_PWR_MIN_MS * 1000000 + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// rail failure to reset asserted, longest
`define CRS_FAIL_MAX_NS    500
`define CRS_FAIL_MAX_CYC   (`CRS_FAIL_MAX_NS / `CRS_CLK_NS)
// wake pulse and gap, least
`define CRS_WAKE_MIN_NS    300
`define CRS_WAKE_MIN_CYC   ((`CRS_WAKE_MIN_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// fall to fall spacing of the processor-active hint
`define CRS_CPU_MIN_NS     700
`define CRS_CPU_MIN_CYC    ((`CRS_CPU_MIN_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
`define CRS_CPU_MAX_NS     1000
`define CRS_CPU_MAX_CYC    (`CRS_CPU_MAX_NS / `CRS_CLK_NS)
`define CRS_CPU_TX_CYC     ((`CRS_CPU_MIN_CYC + `CRS_CPU_MAX_CYC) / 2)
// wake line indeterminate after release, longest
`define CRS_RISE_MAX_NS    100
`define CRS_RISE_MAX_CYC   ((`CRS_RISE_MAX_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// presence settles after the other contacts mate
`define CRS_PRES_MS        1
`define CRS_PRES_CYC       ((`CRS_PRES_MS * 1000000 + `CRS_CLK_NS - 1) / `CRS_CLK_NS)

`endif

// ===== verilog/crs_pkg.sv
// types shared by the system end and the card end of the slot sideband
// assumes crs_regs.svh supplies the timing counts
package crs_pkg;

	// kind of hint the system signals on the wake line
	typedef enum logic [1:0] {
		CRS_HINT_SINGLE     = 2'h1,
		CRS_HINT_CPU_ACTIVE = 2'h2
	} crs_hint_e;

	// system reset sequencer
	typedef enum logic [2:0] {
		CRS_SEQ_OFF  = 3'h1,
		CRS_SEQ_WAIT = 3'h2,
		CRS_SEQ_ON   = 3'h4
	} crs_seq_e;

	// wake line driver, either end
	typedef enum logic [3:0] {
		CRS_WK_IDLE = 4'h1,
		CRS_WK_LOW  = 4'h2,
		CRS_WK_HIGH = 4'h4,
		CRS_WK_GAP  = 4'h8
	} crs_wk_e;

	// card side hint decoder
	typedef enum logic [1:0] {
		CRS_DEC_IDLE  = 2'h1,
		CRS_DEC_ARMED = 2'h2
	} crs_dec_e;

endpackage

// ===== verilog/crs_if.sv
// slot sideband wires between system board and add-in card
// the wake line is open drain with a board pull-up; the level is resolved here
`timescale 1ns/1ns
interface crs_if;
	logic fundamental_reset_n; // reset to card, low active
	logic reference_clock_in_en;           // reference clock supplied to slot
	logic presence_sense_n;    // low when card seated
	logic card_wake_drv;       // card wake drive value
	logic card_wake_oe_n;      // card drives wake while low
	logic sys_wake_drv;        // system wake drive value
	logic sys_wake_oe_n;       // system drives wake while low
	logic wake_n;              // resolved wake line level

	// wired-and with pull-up: high unless somebody drives low
	assign wake_n = !((!card_wake_oe_n && !card_wake_drv) || (!sys_wake_oe_n && !sys_wake_drv));

	modport sys
	(
		output fundamental_reset_n, reference_clock_in_en, sys_wake_drv, sys_wake_oe_n,
		input  presence_sense_n, wake_n
	);
	modport card
	(
		input  fundamental_reset_n, reference_clock_in_en, wake_n,
		output presence_sense_n, card_wake_drv, card_wake_oe_n
	);
endinterface

// ===== verilog/crs_card.sv
// add-in card end: presence, reset synchroniser, wake request driver, hint decoder
// assumes the system end keeps reset, clock and hint timing on the shared wires
`timescale 1ns/1ns
`include "crs_regs.svh"

module crs_card
(
	input  wire logic clk,            // 25 MHz card clock
	input  wire logic rst,            // card local reset, high
	crs_if.card       lnk,            // slot sideband wires
	input  wire logic inserted,       // card fully seated
	input  wire logic wake_req,       // hold high to request wake
	output logic      wake_active,    // card is pulling wake low
	output logic      core_rst_n,     // synchronised fundamental reset
	output logic      hint_cpu_active, // pulse: processor-active hint seen
	output logic      hint_single     // pulse: single-fall hint seen
);
	import crs_pkg::*;

	logic       pres_n_q, pres_n_d;
	logic       rs1_q, rs2_q;
	logic       ws1_q, ws2_q, ws3_q;
	crs_wk_e    wk_q, wk_d;
	logic [4:0] wk_cnt_q, wk_cnt_d;
	crs_dec_e   dec_q, dec_d;
	logic [4:0] dec_cnt_q, dec_cnt_d;
	logic       cpu_q, cpu_d, sgl_q, sgl_d;
	logic       fall;
	logic [4:0] gap;

	////////////////////////////////////////////////////////////////
	// presence and reset; reset has no relation to our clock, so two flops
	always_comb
	begin
		pres_n_d = !inserted;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pres_n_q <= 1'b1;
			rs1_q    <= 1'b0;
			rs2_q    <= 1'b0;
		end
		else
		begin
			pres_n_q <= pres_n_d;
			rs1_q    <= lnk.fundamental_reset_n;
			rs2_q    <= rs1_q;
		end
	end

	assign lnk.presence_sense_n = pres_n_q;
	assign core_rst_n           = rs2_q;

	////////////////////////////////////////////////////////////////
	// wake driver: low or released only, each phase held the least time
	always_comb
	begin
		wk_d     = wk_q;
		wk_cnt_d = wk_cnt_q;
		case (wk_q)
			CRS_WK_IDLE:
				if (wake_req)
				begin
					wk_d     = CRS_WK_LOW;
					wk_cnt_d = 5'h0;
				end
			CRS_WK_LOW:
				if (wk_cnt_q < 5'(`CRS_WAKE_MIN_CYC - 1))
					wk_cnt_d = wk_cnt_q + 5'h1;
				else if (!wake_req)
				begin
					wk_d     = CRS_WK_GAP;
					wk_cnt_d = 5'h0;
				end
			CRS_WK_GAP:
				if (wk_cnt_q == 5'(`CRS_WAKE_MIN_CYC - 1))
					wk_d = CRS_WK_IDLE;
				else
					wk_cnt_d = wk_cnt_q + 5'h1;
			default:
				wk_d = CRS_WK_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wk_q     <= CRS_WK_IDLE;
			wk_cnt_q <= 5'h0;
		end
		else
		begin
			wk_q     <= wk_d;
			wk_cnt_q <= wk_cnt_d;
		end
	end

	assign lnk.card_wake_drv  = 1'b0;
	assign lnk.card_wake_oe_n = (wk_q != CRS_WK_LOW);
	assign wake_active        = (wk_q == CRS_WK_LOW);

	////////////////////////////////////////////////////////////////
	// hint decoder: measure fall to fall on the sampled line
	// our own drive is masked only while the decoder is idle, since its falls would decode as hints
	assign fall = ws3_q && !ws2_q;
	assign gap  = dec_cnt_q + 5'h1;

	always_comb
	begin
		dec_d     = dec_q;
		dec_cnt_d = dec_cnt_q;
		cpu_d     = 1'b0;
		sgl_d     = 1'b0;
		case (dec_q)
			CRS_DEC_IDLE:
				if (fall && wk_q == CRS_WK_IDLE)
				begin
					dec_d     = CRS_DEC_ARMED;
					dec_cnt_d = 5'h0;
				end
			CRS_DEC_ARMED:
				if (fall)
				begin
					dec_d = CRS_DEC_IDLE;
					if (gap >= 5'(`CRS_CPU_MIN_CYC) && gap <= 5'(`CRS_CPU_MAX_CYC))
						cpu_d = 1'b1;
					else
						sgl_d = 1'b1;
				end
				else if (gap > 5'(`CRS_CPU_MAX_CYC))
				begin
					dec_d = CRS_DEC_IDLE;
					sgl_d = 1'b1;
				end
				else
					dec_cnt_d = gap;
			default:
				dec_d = CRS_DEC_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ws1_q     <= 1'b1;
			ws2_q     <= 1'b1;
			ws3_q     <= 1'b1;
			dec_q     <= CRS_DEC_IDLE;
			dec_cnt_q <= 5'h0;
			cpu_q     <= 1'b0;
			sgl_q     <= 1'b0;
		end
		else
		begin
			ws1_q     <= lnk.wake_n;
			ws2_q     <= ws1_q;
			ws3_q     <= ws2_q;
			dec_q     <= dec_d;
			dec_cnt_q <= dec_cnt_d;
			cpu_q     <= cpu_d;
			sgl_q     <= sgl_d;
		end
	end

	assign hint_cpu_active = cpu_q;
	assign hint_single     = sgl_q;
endmodule

// ===== verilog/crs_sys.sv
// system board end: presence qualify, reset sequencer, hint sender, wake receiver
// assumes rails_ok and reference_clock_in_stable come from synchronous monitors on clk
`timescale 1ns/1ns
`include "crs_regs.svh"

// How it works
// - reset low 100us, release 100ms after rails
// - reference clock stable 100us before release
// - assert reset within 500ns of rail failure
// - reset unrelated to reference clock; card synchronises
// - card only pulls wake low or releases
// - wake pulses and gaps last at least 300ns
// - processor-active hint: two falls 700-1000ns apart
// - system may drive hints; card decodes wake
// - presence from sense line sets status bit
// - clock and reset enabled only when present
// - presence settles after 1ms, drops first
// - ignore wake level 100ns after release
module crs_sys #(
	parameter logic [21:0] PWR_STABLE_CYC = 22'(`CRS_PWR_MIN_CYC), // rails stable count
	parameter logic [14:0] PRES_QUAL_CYC  = 15'(`CRS_PRES_CYC)     // presence settle count
)
(
	input  wire logic         clk,             // 25 MHz system clock
	input  wire logic         rst,             // synchronous reset, high
	crs_if.sys                lnk,             // slot sideband wires
	input  wire logic         rails_ok,        // all supplied rails in range
	input  wire logic         reference_clock_in_stable,   // reference clock meets spec
	input  wire logic         hint_req,        // request a hint, taken when idle, reset released and wake line high
	input  wire crs_pkg::crs_hint_e hint_kind, // which hint to send
	output logic              hint_busy,       // hint sender not idle
	output logic              slot_present,    // presence status bit
	output logic              link_reset_done, // fundamental reset released
	output logic              wake_seen        // card is requesting wake
);
	import crs_pkg::*;

	logic [14:0] pres_cnt_q, pres_cnt_d;
	logic        present_q, present_d;
	crs_seq_e    seq_q, seq_d;
	logic [21:0] pwr_cnt_q, pwr_cnt_d;
	logic [11:0] clk_cnt_q, clk_cnt_d;
	logic [11:0] rst_cnt_q, rst_cnt_d;
	logic        rst_n_q, reference_clock_in_en_q;
	logic        pwr_done, clk_done, hold_done, fail;
	crs_wk_e     ht_q, ht_d;
	logic [4:0]  ht_cnt_q, ht_cnt_d;
	logic        second_q, second_d;
	logic [1:0]  low_cnt_q, low_cnt_d;
	logic        seen_q, seen_d;

	////////////////////////////////////////////////////////////////
	// presence: wait for the short fingers to settle, drop at once
	always_comb
	begin
		pres_cnt_d = pres_cnt_q;
		present_d  = present_q;
		if (lnk.presence_sense_n)
		begin
			pres_cnt_d = 15'h0;
			present_d  = 1'b0;
		end
		else if (pres_cnt_q == PRES_QUAL_CYC)
			present_d = 1'b1;
		else
			pres_cnt_d = pres_cnt_q + 15'h1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pres_cnt_q <= 15'h0;
			present_q  <= 1'b0;
		end
		else
		begin
			pres_cnt_q <= pres_cnt_d;
			present_q  <= present_d;
		end
	end

	assign slot_present = present_q;

	////////////////////////////////////////////////////////////////
	// reset sequencer; counters run independently so whichever is slower rules
	assign pwr_done  = (pwr_cnt_q == PWR_STABLE_CYC);
	assign clk_done  = (clk_cnt_q == 12'(`CRS_REFERENCE_CLOCK_IN_MIN_CYC));
	assign hold_done = (rst_cnt_q == 12'(`CRS_RSTLOW_MIN_CYC));
	assign fail      = !rails_ok || !present_q;

	always_comb
	begin
		seq_d     = seq_q;
		pwr_cnt_d = rails_ok ? (pwr_done ? pwr_cnt_q : pwr_cnt_q + 22'h1) : 22'h0;
		clk_cnt_d = (reference_clock_in_stable && reference_clock_in_en_q) ? (clk_done ? clk_cnt_q : clk_cnt_q + 12'h1) : 12'h0;
		rst_cnt_d = (seq_q == CRS_SEQ_ON) ? 12'h0 : (hold_done ? rst_cnt_q : rst_cnt_q + 12'h1);
		case (seq_q)
			CRS_SEQ_OFF:
				if (!fail)
					seq_d = CRS_SEQ_WAIT;
			CRS_SEQ_WAIT:
				if (fail)
					seq_d = CRS_SEQ_OFF;
				else if (pwr_done && clk_done && hold_done)
					seq_d = CRS_SEQ_ON;
			CRS_SEQ_ON:
				if (fail)
					seq_d = CRS_SEQ_OFF;
			default:
				seq_d = CRS_SEQ_OFF;
		endcase
	end

	// reset drops one edge after a rail failure, well inside the allowed time
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			seq_q       <= CRS_SEQ_OFF;
			pwr_cnt_q   <= 22'h0;
			clk_cnt_q   <= 12'h0;
			rst_cnt_q   <= 12'h0;
			rst_n_q     <= 1'b0;
			reference_clock_in_en_q <= 1'b0;
		end
		else
		begin
			seq_q       <= seq_d;
			pwr_cnt_q   <= pwr_cnt_d;
			clk_cnt_q   <= clk_cnt_d;
			rst_cnt_q   <= rst_cnt_d;
			rst_n_q     <= (seq_d == CRS_SEQ_ON);
			reference_clock_in_en_q <= present_d;
		end
	end

	// no alignment to the reference clock is attempted
	assign lnk.fundamental_reset_n = rst_n_q;
	assign lnk.reference_clock_in_en           = reference_clock_in_en_q;
	assign link_reset_done         = rst_n_q;

	////////////////////////////////////////////////////////////////
	// hint sender: low, then high and a second low for the processor-active hint only, then a closing gap
	always_comb
	begin
		ht_d     = ht_q;
		ht_cnt_d = ht_cnt_q + 5'h1;
		second_d = second_q;
		case (ht_q)
			CRS_WK_IDLE:
			begin
				ht_cnt_d = 5'h0;
				if (hint_req && rst_n_q && lnk.wake_n)
				begin
					ht_d     = CRS_WK_LOW;
					second_d = (hint_kind == CRS_HINT_CPU_ACTIVE);
				end
			end
			CRS_WK_LOW:
				if (ht_cnt_q[4:0] >= 5'(`CRS_WAKE_MIN_CYC - 1) && !second_q && ht_d == CRS_WK_LOW)
				begin
					ht_d     = CRS_WK_GAP;
					ht_cnt_d = 5'h0;
				end
				else if (ht_cnt_q == 5'(`CRS_WAKE_MIN_CYC - 1))
					ht_d = CRS_WK_HIGH;
			CRS_WK_HIGH:
				if (ht_cnt_q == 5'(`CRS_CPU_TX_CYC - 1))
				begin
					ht_d     = CRS_WK_LOW;
					ht_cnt_d = 5'h0;
					second_d = 1'b0;
				end
			CRS_WK_GAP:
				if (ht_cnt_q == 5'(`CRS_WAKE_MIN_CYC - 1))
					ht_d = CRS_WK_IDLE;
			default:
				ht_d = CRS_WK_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ht_q     <= CRS_WK_IDLE;
			ht_cnt_q <= 5'h0;
			second_q <= 1'b0;
		end
		else
		begin
			ht_q     <= ht_d;
			ht_cnt_q <= ht_cnt_d;
			second_q <= second_d;
		end
	end

	assign lnk.sys_wake_drv  = 1'b0;
	assign lnk.sys_wake_oe_n = (ht_q != CRS_WK_LOW);
	assign hint_busy         = (ht_q != CRS_WK_IDLE);

	////////////////////////////////////////////////////////////////
	// wake receiver: a low must outlast the rise window before it counts,
	// so the slow pull-up after any release never reads as a request
	always_comb
	begin
		low_cnt_d = low_cnt_q;
		seen_d    = 1'b0;
		if (lnk.wake_n || ht_q != CRS_WK_IDLE)
			low_cnt_d = 2'h0;
		else if (low_cnt_q != 2'(`CRS_RISE_MAX_CYC))
			low_cnt_d = low_cnt_q + 2'h1;
		else
			seen_d = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			low_cnt_q <= 2'h0;
			seen_q    <= 1'b0;
		end
		else
		begin
			low_cnt_q <= low_cnt_d;
			seen_q    <= seen_d;
		end
	end

	assign wake_seen = seen_q;
endmodule

// ===== tb/crs_link_asserts.sv
// concurrent checks on the slot sideband wires between system end and card end
// assumes one clock, synchronous active-high reset, and the wires of crs_if
`timescale 1ns/1ns
`include "crs_regs.svh"

module crs_link_asserts #(
	parameter logic [14:0] PRES_QUAL_CYC = 15'(`CRS_PRES_CYC) // presence settle count
)
(
	input wire logic clk,                 // system clock
	input wire logic rst,                 // synchronous reset, high
	input wire logic fundamental_reset_n, // reset to card
	input wire logic reference_clock_in_en,           // reference clock supplied
	input wire logic presence_sense_n,    // low while card seated
	input wire logic card_wake_drv,       // card drive value
	input wire logic card_wake_oe_n,      // card pulls while low
	input wire logic sys_wake_drv,        // system drive value
	input wire logic sys_wake_oe_n,       // system pulls while low
	input wire logic wake_n               // resolved wake line
);
	localparam int RST_LOW_MIN = `CRS_RSTLOW_MIN_CYC;
	localparam int CLK_RUN_MIN = `CRS_REFERENCE_CLOCK_IN_MIN_CYC;
	localparam int FALL_MIN    = `CRS_CPU_MIN_CYC;
	localparam int FALL_MAX    = `CRS_CPU_MAX_CYC;

	logic        sys_oe_q;
	logic        sys_oe_d;
	logic [5:0]  gap_q;
	logic [5:0]  gap_d;
	logic [15:0] pres_q;
	logic [15:0] pres_d;
	logic [11:0] low_q;
	logic [11:0] low_d;
	logic [11:0] run_q;
	logic [11:0] run_d;

	////////////////////////////////////////
	// saturating observation counters; they saturate so that long idle spans never wrap into a false pass
	always_comb
	begin
		sys_oe_d = sys_wake_oe_n;
		gap_d    = (sys_oe_q && !sys_wake_oe_n) ? 6'h01 : gap_q + {5'h0, gap_q != 6'h3f};
		pres_d   = presence_sense_n ? 16'h0 : pres_q + {15'h0, pres_q != 16'hffff};
		low_d    = fundamental_reset_n ? 12'h0 : low_q + {11'h0, low_q != 12'hfff};
		run_d    = reference_clock_in_en ? run_q + {11'h0, run_q != 12'hfff} : 12'h0;
		if (rst)
		begin
			sys_oe_d = 1'b1;
			gap_d    = 6'h3f;
			pres_d   = 16'h0;
			low_d    = 12'h0;
			run_d    = 12'h0;
		end
	end

	// registers only
	always_ff @(posedge clk)
	begin
		sys_oe_q <= sys_oe_d;
		gap_q    <= gap_d;
		pres_q   <= pres_d;
		low_q    <= low_d;
		run_q    <= run_d;
	end

	////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence card_held_low_s;
		!card_wake_oe_n [*8];
	endsequence

	sequence card_held_off_s;
		card_wake_oe_n [*8];
	endsequence

	sequence slot_empty_s;
		presence_sense_n [*3];
	endsequence

	card_low_only_a: assert property (!card_wake_oe_n |-> !card_wake_drv)
		else $error("card drives the wake line high");
	sys_low_only_a: assert property (!sys_wake_oe_n |-> !sys_wake_drv)
		else $error("system drives the wake line high");
	card_pulse_min_a: assert property ($fell(card_wake_oe_n) |-> card_held_low_s)
		else $error("card wake pulse too short");
	card_gap_min_a: assert property ($rose(card_wake_oe_n) |-> card_held_off_s)
		else $error("card wake gap too short");
	sys_pulse_min_a: assert property ($fell(sys_wake_oe_n) |=> !sys_wake_oe_n [*7] ##1 1'b1)
		else $error("system wake pulse too short");
	sys_start_idle_a: assert property ($fell(sys_wake_oe_n) |-> $past(wake_n))
		else $error("system starts a hint on a busy line");
	cpu_fall_space_a: assert property ($fell(sys_wake_oe_n) && int'(gap_q) <= FALL_MAX |-> int'(gap_q) >= FALL_MIN)
		else $error("falls on the wake line too close together");
	clock_gate_pres_a: assert property (presence_sense_n [*2] |-> !reference_clock_in_en)
		else $error("reference clock enabled to an empty slot");
	reset_gate_pres_a: assert property (slot_empty_s |-> !fundamental_reset_n)
		else $error("reset released to an empty slot");
	pres_settle_a: assert property ($rose(reference_clock_in_en) |-> pres_q >= 16'(PRES_QUAL_CYC) + 16'h1)
		else $error("slot enabled before presence settled");
	reset_low_time_a: assert property ($rose(fundamental_reset_n) |-> int'(low_q) >= RST_LOW_MIN)
		else $error("reset low time too short");
	clock_before_rel_a: assert property ($rose(fundamental_reset_n) |-> int'(run_q) >= CLK_RUN_MIN)
		else $error("reset released before the clock ran long enough");
endmodule

// ===== tb/tb_card_reset_wake_presence.sv
// self-checking bench: system end and card end joined over the slot sideband
// assumes shortened power and presence counts; clock and reset hold counts stay full
`timescale 1ns/1ns
`include "crs_regs.svh"

module tb_card_reset_wake_presence;
	import crs_pkg::*;

	localparam logic [21:0] PWR_CYC  = 22'h000032; // rails stable, shortened
	localparam logic [14:0] PRES_CYC = 15'h0014;   // presence settle, shortened
	localparam int          HOLD_CYC = 2500;       // reset low and clock stable

	logic        clk = 1'b0;
	logic        rst;
	logic        rails_ok;
	logic        reference_clock_in_stable;
	logic        hint_req;
	crs_hint_e   hint_kind;
	logic        hint_busy;
	logic        slot_present;
	logic        link_reset_done;
	logic        wake_seen;
	logic        inserted;
	logic        wake_req;
	logic        wake_active;
	logic        core_rst_n;
	logic        hint_cpu_active;
	logic        hint_single;
	logic [7:0]  exp_q[$];
	logic [5:0]  prev_q;
	logic [31:0] seed = 32'h00006ebd;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          ev_cyc[12];
	int          mark;
	int          n;

	crs_if lnk();

	crs_sys #(.PWR_STABLE_CYC(PWR_CYC), .PRES_QUAL_CYC(PRES_CYC)) u_crs_sys (.clk(clk), .rst(rst), .lnk(lnk),
		.rails_ok(rails_ok), .reference_clock_in_stable(reference_clock_in_stable), .hint_req(hint_req), .hint_kind(hint_kind),
		.hint_busy(hint_busy), .slot_present(slot_present), .link_reset_done(link_reset_done), .wake_seen(wake_seen));

	crs_card u_crs_card (.clk(clk), .rst(rst), .lnk(lnk), .inserted(inserted), .wake_req(wake_req),
		.wake_active(wake_active), .core_rst_n(core_rst_n), .hint_cpu_active(hint_cpu_active), .hint_single(hint_single));

	crs_link_asserts #(.PRES_QUAL_CYC(PRES_CYC)) u_crs_link_asserts (.clk(clk), .rst(rst),
		.fundamental_reset_n(lnk.fundamental_reset_n), .reference_clock_in_en(lnk.reference_clock_in_en), .presence_sense_n(lnk.presence_sense_n),
		.card_wake_drv(lnk.card_wake_drv), .card_wake_oe_n(lnk.card_wake_oe_n), .sys_wake_drv(lnk.sys_wake_drv),
		.sys_wake_oe_n(lnk.sys_wake_oe_n), .wake_n(lnk.wake_n));

	////////////////////////////////////////
	// 25 MHz clock
	always #20 clk = ~clk;

	// event code: 16 plus output index times two plus direction
	function automatic logic [7:0] ev(input int idx, input logic up);
		ev = 8'(8'h10 + idx * 2 + int'(up));
	endfunction

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction

	// inputs always change 2 ns after the rising edge
	task automatic tick(input int cycles);
		repeat (cycles)
		begin
			@(posedge clk);
			#2;
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp_evt(input logic [7:0] exp, input logic [7:0] act);
		comparisons++;
		if (act !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: event expected %h actual %h", $time, exp, act);
		end
	endtask

	task automatic cmp_bit(input logic exp, input logic act);
		comparisons++;
		if (act !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: level expected %h actual %h", $time, exp, act);
		end
	endtask

	// bounded wait until every note has been matched; running out ends the run
	task automatic drain(input int bound);
		n = 0;
		while (exp_q.size() != 0 && n < bound)
		begin
			tick(1);
			n++;
		end
		if (exp_q.size() != 0)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: wait ran out, expected %h actual %h", $time, exp_q[0], 8'h00);
			complete_run();
		end
	endtask

	////////////////////////////////////////
	// watcher: every output change except the fall of a hint pulse takes the oldest note; a change with no note is a mismatch
	always @(negedge clk)
	begin
		logic [5:0] cur;
		cur = {hint_single, hint_cpu_active, wake_seen, core_rst_n, link_reset_done, slot_present};
		cyc++;
		if (!rst)
			for (int i = 0; i < 6; i++)
				if (cur[i] !== prev_q[i] && (i < 4 || cur[i] === 1'b1))
				begin
					ev_cyc[i * 2 + int'(cur[i] === 1'b1)] = cyc;
					cmp_evt(exp_q.size() != 0 ? exp_q.pop_front() : 8'h00, ev(i, cur[i] === 1'b1));
				end
		prev_q = cur;
	end

	initial
	begin
		rst = 1'b1;
		rails_ok = 1'b1;
		reference_clock_in_stable = 1'b0;
		hint_req = 1'b0;
		hint_kind = CRS_HINT_SINGLE;
		inserted = 1'b0;
		wake_req = 1'b0;
		tick(4);
		cmp_bit(1'b0, slot_present);
		cmp_bit(1'b0, core_rst_n);
		rst = 1'b0;
		// insertion with no stable clock: presence only, reset held, hints refused
		exp_q.push_back(ev(0, 1'b1));
		inserted = 1'b1;
		drain(40);
		hint_req = 1'b1;
		tick(1);
		hint_req = 1'b0;
		tick(3000);
		cmp_bit(1'b0, link_reset_done);
		cmp_bit(1'b0, hint_busy);
		// clock stable: release only after the full clock interval
		mark = cyc;
		exp_q.push_back(ev(1, 1'b1));
		exp_q.push_back(ev(2, 1'b1));
		reference_clock_in_stable = 1'b1;
		drain(2700);
		cmp_bit(1'b1, ev_cyc[3] - mark >= HOLD_CYC);
		cmp_bit(1'b1, ev_cyc[5] - ev_cyc[3] == 2);
		// rail failure: prompt reset, then a full power-up and hold interval
		exp_q.push_back(ev(1, 1'b0));
		exp_q.push_back(ev(2, 1'b0));
		mark = cyc;
		rails_ok = 1'b0;
		drain(20);
		cmp_bit(1'b1, ev_cyc[2] - mark <= `CRS_FAIL_MAX_CYC);
		tick(4);
		exp_q.push_back(ev(1, 1'b1));
		exp_q.push_back(ev(2, 1'b1));
		mark = cyc;
		rails_ok = 1'b1;
		drain(2700);
		cmp_bit(1'b1, ev_cyc[3] - mark >= int'(PWR_CYC));
		cmp_bit(1'b1, ev_cyc[3] - ev_cyc[2] >= HOLD_CYC);
		// both hint kinds; a second request while busy must be dropped
		for (int k = 0; k < 2; k++)
		begin
			hint_kind = (k == 0) ? CRS_HINT_CPU_ACTIVE : CRS_HINT_SINGLE;
			exp_q.push_back(ev(4 + k, 1'b1));
			hint_req = 1'b1;
			tick(1);
			hint_req = 1'b0;
			tick(3);
			cmp_bit(1'b1, hint_busy);
			hint_req = 1'b1;
			tick(1);
			hint_req = 1'b0;
			drain(80);
			tick(60);
		end
		// card wake requests of random length; the system sees each pull and release
		for (int k = 0; k < 3; k++)
		begin
			seed = xs(seed);
			exp_q.push_back(ev(3, 1'b1));
			exp_q.push_back(ev(3, 1'b0));
			wake_req = 1'b1;
			tick(1 + int'(seed[3:0]));
			cmp_bit(1'b1, wake_active);
			wake_req = 1'b0;
			drain(60);
			tick(10 + int'(seed[9:4]));
		end
		// removal: presence and clock drop together, then reset is withdrawn
		exp_q.push_back(ev(0, 1'b0));
		exp_q.push_back(ev(1, 1'b0));
		exp_q.push_back(ev(2, 1'b0));
		inserted = 1'b0;
		drain(20);
		tick(10);
		complete_run();
	end
endmodule
